//--- design/serial_baud_rate_generator.sv
// Baud rate divider timer with a classic Wishbone register slave
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module serial_baud_rate_generator (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Wishbone classic slave
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    input  wire logic [7:0]  adr,
    input  wire logic [3:0]  sel,
    input  wire logic [31:0] datWr,
    output logic      [31:0] datRd,
    output logic             ack,
    // Receiver status in
    input  wire logic        rxIdle,
    // Rate outputs
    output logic             rateTick,
    output var rate_divider_pkg::rate_cfg_t rateCfg
);

    // ==========================================
    // Reset release
    logic rstMeta_q;                         // First stage, feeds only the second
    logic rstN;                              // Released reset for the design

    // Release through two stages so all flops leave reset together
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstN      <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN      <= rstMeta_q;
        end
    end

    // ==========================================
    // Functions
    // Multiplier minus one from the mode bits
    function automatic logic [5:0] multM1(input logic syncM, input logic wide,
                                          input logic fast);
        if (syncM) begin
            multM1 = rate_divider_pkg::MULT4_M1;
        end else if (wide && fast) begin
            multM1 = rate_divider_pkg::MULT4_M1;
        end else if (wide || fast) begin
            multM1 = rate_divider_pkg::MULT16_M1;
        end else begin
            multM1 = rate_divider_pkg::MULT64_M1;
        end
    endfunction : multM1

    // ==========================================
    // Bus slave
    logic [7:0]  baudCtl_q;                  // Writable baud_control bits
    logic [7:0]  recvCtl_q;                  // Writable receive_control bits
    logic [7:0]  xmitCtl_q;                  // Writable transmit_control bits
    logic [7:0]  divLow_q;                   // divisor_low_byte
    logic [7:0]  divHigh_q;                  // divisor_high_byte
    logic        ack_q;                      // Answer strobe
    logic [31:0] datRd_q;                    // Read data
    logic        request;                    // Access pending, not yet answered
    logic        wrCommit;                   // Write takes effect this edge
    logic        divWrite;                   // Either divisor byte written
    logic [7:0]  readByte;                   // Decoded read value

    assign request  = cyc && stb && !ack_q;
    // Writes land on the edge where the master sees ack
    assign wrCommit = cyc && stb && we && ack_q && sel[0];
    assign divWrite = wrCommit && (adr == rate_divider_pkg::OFS_DIVISOR_LOW ||
                                   adr == rate_divider_pkg::OFS_DIVISOR_HIGH);
    assign ack      = ack_q;
    assign datRd    = datRd_q;

    // Read decode; unmapped offsets read zero
    always_comb begin
        readByte = rate_divider_pkg::RST_BYTE;
        case (adr)
            rate_divider_pkg::OFS_BAUD_CONTROL: begin
                readByte = baudCtl_q;
                readByte[rate_divider_pkg::BIT_RX_IDLE] = rxIdle;
            end
            rate_divider_pkg::OFS_RECEIVE_CONTROL: readByte = recvCtl_q;
            rate_divider_pkg::OFS_DIVISOR_LOW:     readByte = divLow_q;
            rate_divider_pkg::OFS_DIVISOR_HIGH:    readByte = divHigh_q;
            rate_divider_pkg::OFS_TRANSMIT_CTRL: begin
                readByte = xmitCtl_q;
                // No shifter here, so it always reads empty
                readByte[rate_divider_pkg::BIT_SHIFT_MT] = 1'b1;
            end
            default: readByte = rate_divider_pkg::RST_BYTE;
        endcase
    end

    // Answer one cycle after the request, drop the cycle after
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ack_q   <= 1'b0;
            datRd_q <= 32'h0000_0000;
        end else begin
            ack_q <= request;
            if (request) begin
                datRd_q <= {24'h00_0000, readByte};
            end
        end
    end

    // Control register writes; unmapped writes are dropped
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            baudCtl_q <= rate_divider_pkg::RST_BYTE;
            recvCtl_q <= rate_divider_pkg::RST_BYTE;
            xmitCtl_q <= rate_divider_pkg::RST_BYTE;
            divLow_q  <= rate_divider_pkg::RST_BYTE;
            divHigh_q <= rate_divider_pkg::RST_BYTE;
        end else if (wrCommit) begin
            case (adr)
                rate_divider_pkg::OFS_BAUD_CONTROL:
                    baudCtl_q <= datWr[7:0] & rate_divider_pkg::MASK_BAUD_WR;
                rate_divider_pkg::OFS_RECEIVE_CONTROL:
                    recvCtl_q <= datWr[7:0] & rate_divider_pkg::MASK_RECV_WR;
                rate_divider_pkg::OFS_DIVISOR_LOW:
                    divLow_q  <= datWr[7:0];
                rate_divider_pkg::OFS_DIVISOR_HIGH:
                    divHigh_q <= datWr[7:0];
                rate_divider_pkg::OFS_TRANSMIT_CTRL:
                    xmitCtl_q <= datWr[7:0] & rate_divider_pkg::MASK_XMIT_WR;
                default: ;
            endcase
        end
    end

    // ==========================================
    // Configuration
    rate_divider_pkg::rate_cfg_t cfg;        // Live mode and divisor
    logic [5:0] preEnd;                      // Last prescaler count

    always_comb begin
        cfg.syncMode = xmitCtl_q[rate_divider_pkg::BIT_SYNC_MODE];
        cfg.wideSel  = baudCtl_q[rate_divider_pkg::BIT_WIDE_SEL];
        cfg.fastSel  = xmitCtl_q[rate_divider_pkg::BIT_FAST_SEL];
        // Narrow mode uses only the low byte
        cfg.divisor  = cfg.wideSel ? {divHigh_q, divLow_q}
                                   : {8'h00, divLow_q};
    end

    assign preEnd  = multM1(cfg.syncMode, cfg.wideSel, cfg.fastSel);
    assign rateCfg = cfg;

    // ==========================================
    // Divider timer
    logic [5:0]  pre_q;                      // Multiplier prescaler
    logic [15:0] cnt_q;                      // Divisor step counter
    logic        rateTick_q;                 // One-cycle rate pulse
    logic        preWrap;                    // Prescaler at its end
    logic        cntWrap;                    // Period complete

    // Greater-or-equal recovers if a mode change leaves the count beyond its end
    assign preWrap  = pre_q >= preEnd;
    assign cntWrap  = preWrap && (cnt_q >= cfg.divisor);
    assign rateTick = rateTick_q;

    // Free running count of mult*(n+1) cycles
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            pre_q      <= 6'h00;
            cnt_q      <= 16'h0000;
            rateTick_q <= 1'b0;
        end else if (divWrite) begin
            // New divisor restarts at once, no wait for the old period
            pre_q      <= 6'h00;
            cnt_q      <= 16'h0000;
            rateTick_q <= 1'b0;
        end else begin
            rateTick_q <= cntWrap;
            if (preWrap) begin
                pre_q <= 6'h00;
                cnt_q <= cntWrap ? 16'h0000 : cnt_q + 16'h0001;
            end else begin
                pre_q <= pre_q + 6'h01;
            end
        end
    end

    // ==========================================
    // Assertions
    logic [22:0] gap_q;                      // Cycles since period start
    logic        steady_q;                   // No write since last tick
    logic [22:0] periodLen;                  // Expected period length

    // Widest case is 16 * 65536, which still fits in 23 bits
    assign periodLen = 23'({17'h0_0000, preEnd} + 23'h00_0001)
                     * 23'({7'h00, cfg.divisor} + 23'h00_0001);

    // Track the period length between ticks under a steady setup
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            gap_q    <= 23'h00_0000;
            steady_q <= 1'b0;
        end else if (wrCommit) begin
            gap_q    <= 23'h00_0000;
            steady_q <= 1'b0;
        end else if (rateTick_q) begin
            gap_q    <= 23'h00_0001;
            steady_q <= 1'b1;
        end else begin
            gap_q    <= gap_q + 23'h00_0001;
        end
    end

    sequence divWriteSeen;
        divWrite;
    endsequence

    sequence timerCleared;
        pre_q == 6'h00 && cnt_q == 16'h0000 && !rateTick_q;
    endsequence

    a_period_exact: assert property (@(posedge core_clk) disable iff (!rstN)
        rateTick_q && steady_q && !wrCommit |-> gap_q == periodLen)
        else $error("rate period differs from mult*(n+1)");

    a_write_restart: assert property (@(posedge core_clk) disable iff (!rstN)
        divWriteSeen |=> timerCleared)
        else $error("divisor write did not restart the timer");

    a_reset_narrow: assert property (@(posedge core_clk) disable iff (!rstN)
        $rose(rstN) |-> !cfg.wideSel && preEnd == rate_divider_pkg::MULT64_M1)
        else $error("timer not narrow after reset");

    a_sync_mult: assert property (@(posedge core_clk) disable iff (!rstN)
        cfg.syncMode |-> preEnd == rate_divider_pkg::MULT4_M1)
        else $error("sync mode multiplier is not four");

    a_async_slow: assert property (@(posedge core_clk) disable iff (!rstN)
        !cfg.syncMode && !cfg.fastSel
        |-> preEnd == (cfg.wideSel ? rate_divider_pkg::MULT16_M1 : rate_divider_pkg::MULT64_M1))
        else $error("async low speed multiplier wrong");

    a_async_fast: assert property (@(posedge core_clk) disable iff (!rstN)
        !cfg.syncMode && cfg.fastSel
        |-> preEnd == (cfg.wideSel ? rate_divider_pkg::MULT4_M1 : rate_divider_pkg::MULT16_M1))
        else $error("async high speed multiplier wrong");

    a_narrow_low: assert property (@(posedge core_clk) disable iff (!rstN)
        !cfg.wideSel |-> cfg.divisor == {8'h00, divLow_q})
        else $error("narrow divisor uses high byte");

    a_wide_bit: assert property (@(posedge core_clk) disable iff (!rstN)
        wrCommit && adr == rate_divider_pkg::OFS_BAUD_CONTROL
        |=> cfg.wideSel == $past(datWr[rate_divider_pkg::BIT_WIDE_SEL]))
        else $error("wide select not taken from bit 3");

    a_idle_read: assert property (@(posedge core_clk) disable iff (!rstN)
        request && !we && adr == rate_divider_pkg::OFS_BAUD_CONTROL
        |=> ack_q && datRd_q[rate_divider_pkg::BIT_RX_IDLE] == $past(rxIdle))
        else $error("idle flag read back wrong");

    a_tick_single: assert property (@(posedge core_clk) disable iff (!rstN)
        rateTick_q && preEnd != 6'h00 |=> !rateTick_q)
        else $error("rate tick longer than one cycle");

endmodule : serial_baud_rate_generator

`default_nettype wire

//--- design/rate_divider_pkg.sv
// Constants and types shared by the serial rate divider
`default_nettype none

package rate_divider_pkg;

    // ==========================================
    // Register word offsets (byte addresses)
    localparam logic [7:0] OFS_BAUD_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_RECEIVE_CONTROL = 8'h04;
    localparam logic [7:0] OFS_DIVISOR_LOW     = 8'h08;
    localparam logic [7:0] OFS_DIVISOR_HIGH    = 8'h0c;
    localparam logic [7:0] OFS_TRANSMIT_CTRL   = 8'h10;

    // ==========================================
    // Field positions
    localparam int BIT_RX_IDLE   = 6;        // baud_control, read only
    localparam int BIT_WIDE_SEL  = 3;        // baud_control
    localparam int BIT_SYNC_MODE = 4;        // transmit_control
    localparam int BIT_FAST_SEL  = 2;        // transmit_control
    localparam int BIT_SHIFT_MT  = 1;        // transmit_control, reads one

    // Writable bit masks; other bits read zero, except the rx idle flag and shifter empty, which reads one
    localparam logic [7:0] MASK_BAUD_WR = 8'h1b;
    localparam logic [7:0] MASK_RECV_WR = 8'hf8;
    localparam logic [7:0] MASK_XMIT_WR = 8'hfd;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ==========================================
    // Divide multipliers, stored as multiplier minus one
    localparam logic [5:0] MULT64_M1 = 6'h3f;
    localparam logic [5:0] MULT16_M1 = 6'h0f;
    localparam logic [5:0] MULT4_M1  = 6'h03;

    // Rate configuration carried to the timer
    typedef struct packed {
        logic        syncMode;   // One selects synchronous operation
        logic        wideSel;    // One selects the 16-bit divisor
        logic        fastSel;    // High speed in asynchronous mode
        logic [15:0] divisor;    // Divisor n, high byte over low
    } rate_cfg_t;

endpackage : rate_divider_pkg

`default_nettype wire

//--- testbench/test_serial_baud_rate_generator.sv
// Self-checking bench for the serial baud rate divider
`timescale 1ns/1ns
`default_nettype none

module test_serial_baud_rate_generator;

    // ==========================================
    // Stimulus and observed signals
    logic                         core_clk = 1'b0;  // 100 MHz system clock
    logic                         rst_n    = 1'b0;  // Active low reset
    logic                         cyc      = 1'b0;  // Bus cycle
    logic                         stb      = 1'b0;  // Bus strobe
    logic                         we       = 1'b0;  // Write direction
    logic [7:0]                   adr      = 8'h00; // Byte address
    logic [3:0]                   sel      = 4'h0;  // Byte enables
    logic [31:0]                  datWr    = 32'h0; // Write data
    logic                         rxIdle   = 1'b1;  // Receiver idle level
    logic [31:0]                  datRd;            // Read data
    logic                         ack;              // Bus answer
    logic                         rateTick;         // Divider tick
    rate_divider_pkg::rate_cfg_t  rateCfg;          // Live configuration
    int                           err_count = 0;    // Mismatches
    int                           n_checks  = 0;    // Comparisons made
    int                           cycles    = 0;    // Timeout counter

    // Whole run is near 13k cycles; ceiling leaves margin
    localparam int LIMIT = 20000;

    serial_baud_rate_generator DUT (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .cyc      (cyc),
        .stb      (stb),
        .we       (we),
        .adr      (adr),
        .sel      (sel),
        .datWr    (datWr),
        .datRd    (datRd),
        .ack      (ack),
        .rxIdle   (rxIdle),
        .rateTick (rateTick),
        .rateCfg  (rateCfg)
    );

    // Clock generator
    always #5 core_clk = ~core_clk;

    // Hang guard: counts as a mismatch and ends the run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            close_out();
        end
    end

    // ==========================================
    // Reporting
    task automatic close_out();
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // ==========================================
    // Classic single bus cycle; holds until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        @(posedge core_clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= s;
        datWr <= {24'h0, d};
        do @(posedge core_clk); while (ack !== 1'b1);
        q = datRd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'h1, q);
    endtask : wr

    // Read one register; the whole word is compared, upper bits must read zero
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, 4'h1, q);
        chk(what, {24'h0, exp}, q);
    endtask : rd_chk

    // Edges from now until the tick is seen; capped so a dead timer cannot hang
    task automatic measure(output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            cnt++;
            #1;
        end while (rateTick !== 1'b1 && cnt < 5000);
    endtask : measure

    // ==========================================
    // Scenario: registers after reset and write masks
    task automatic regs_scenario();
        chk("cfg after reset", 32'h0, {13'h0, rateCfg});
        rd_chk("baud reset", rate_divider_pkg::OFS_BAUD_CONTROL, 8'h40);
        rd_chk("xmit reset", rate_divider_pkg::OFS_TRANSMIT_CTRL, 8'h02);
        rd_chk("high reset", rate_divider_pkg::OFS_DIVISOR_HIGH, 8'h00);
        wr(rate_divider_pkg::OFS_BAUD_CONTROL, 8'hff);
        rd_chk("baud mask", rate_divider_pkg::OFS_BAUD_CONTROL, 8'h5b);
        @(posedge core_clk) rxIdle <= 1'b0;
        // Software polls the idle flag before touching the clock setup
        rd_chk("idle low", rate_divider_pkg::OFS_BAUD_CONTROL, 8'h1b);
        wr(rate_divider_pkg::OFS_RECEIVE_CONTROL, 8'hff);
        rd_chk("recv mask", rate_divider_pkg::OFS_RECEIVE_CONTROL, 8'hf8);
        wr(8'h14, 8'hff);
        rd_chk("unmapped", 8'h14, 8'h00);
        begin
            logic [31:0] q;
            wb(1'b1, rate_divider_pkg::OFS_DIVISOR_LOW, 8'h55, 4'h0, q);
        end
        rd_chk("sel ignored", rate_divider_pkg::OFS_DIVISOR_LOW, 8'h00);
    endtask : regs_scenario

    // Scenario: one rate mode, first tick after divisor write and the period
    task automatic run_mode(input logic s, input logic w, input logic f,
                            input logic [15:0] n, input int mult);
        logic [15:0] eff;
        int          cnt;
        // Narrow mode uses the low byte only
        eff = w ? n : {8'h00, n[7:0]};
        wr(rate_divider_pkg::OFS_TRANSMIT_CTRL, {3'b000, s, 1'b0, f, 2'b00});
        wr(rate_divider_pkg::OFS_BAUD_CONTROL, {4'h0, w, 3'b000});
        wr(rate_divider_pkg::OFS_DIVISOR_HIGH, n[15:8]);
        wr(rate_divider_pkg::OFS_DIVISOR_LOW, n[7:0]);
        // Registers update at the ack edge; look once they have settled
        @(negedge core_clk);
        chk("cfg", {13'h0, s, w, f, eff}, {13'h0, rateCfg});
        measure(cnt);
        chk("first tick", mult * (eff + 1), cnt);
        measure(cnt);
        chk("period", mult * (eff + 1), cnt);
    endtask : run_mode

    // ==========================================
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        regs_scenario();
        run_mode(1'b0, 1'b0, 1'b0, 16'h0203, 64);
        run_mode(1'b0, 1'b0, 1'b1, 16'h0203, 16);
        run_mode(1'b0, 1'b1, 1'b0, 16'h0102, 16);
        // Preferred low-error setup: high speed with the wide divider
        run_mode(1'b0, 1'b1, 1'b1, 16'h0102, 4);
        run_mode(1'b1, 1'b0, 1'b1, 16'h0205, 4);
        run_mode(1'b1, 1'b1, 1'b0, 16'h0102, 4);
        close_out();
    end

endmodule : test_serial_baud_rate_generator

`default_nettype wire
